// [design/crt_pkg.sv]
// Package: constants and types for the current range and trigger controller
package crt_pkg;
   // Clock and conversion timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CONV_HZ = 250_000;
   localparam int CONV_DIV = CLK_HZ / CONV_HZ;
   localparam int MASK_TIME_US = 1000;
   localparam int MASK_CONV = MASK_TIME_US * CONV_HZ / 1_000_000;
   localparam int OVER_RATE_HZ = 2000;
   localparam int UNDER_RATE_HZ = 2;
   localparam int OVER_GAP = CLK_HZ / OVER_RATE_HZ;
   localparam int UNDER_GAP = CLK_HZ / UNDER_RATE_HZ;
   localparam int MIN_PERIOD_US = 100;
   localparam int MIN_AVG_CONV = MIN_PERIOD_US * CONV_HZ / 1_000_000;
   // Range field: bits [3:2] pick the feedback resistor, [1:0] pick the gain
   localparam int RANGE_W = 4;
   localparam logic [3:0] RANGE_FIRST = 4'h0;
   localparam logic [3:0] RANGE_LAST = 4'hF;
   localparam logic [3:0] RANGE_LAST_HC = 4'hE;
   localparam logic [1:0] GAIN_X1 = 2'h3;
   // Thresholds in percent of full scale
   localparam int OVER_PCT = 80;
   localparam int UNDER_PCT = 20;
   localparam int PCT_FULL = 100;
   localparam int SAMPLE_W = 16;
   localparam logic [15:0] FULL_SCALE = 16'h7FFF;
   // Trigger modes
   typedef enum logic [1:0] {
      CRT_TRG_INTERNAL = 2'b00,
      CRT_TRG_GATE_START = 2'b01,
      CRT_TRG_GATE_START_STOP = 2'b10,
      CRT_TRG_MESSAGE = 2'b11
   } crt_mode_e;
   // Sequencer states
   typedef enum logic [1:0] {
      CRT_IDLE = 2'b00,
      CRT_ARMED = 2'b01,
      CRT_RUN = 2'b10
   } crt_seq_e;
   // Status indicator codes
   localparam logic [1:0] LED_OFF = 2'h0;
   localparam logic [1:0] LED_ORANGE = 2'h1;
   localparam logic [1:0] LED_GREEN = 2'h2;
endpackage

// [design/crt_range_check.sv]
// Range flags: per-sample over and under thresholds against full scale
`timescale 1ns/1ns
module crt_range_check
   import crt_pkg::*;
#(
   parameter int W = SAMPLE_W
) (
   input wire logic signed [W-1:0] sample,
   output logic over,
   output logic under
);
   logic [W:0] mag;
   logic [W+7:0] scaled;
   logic [W+7:0] lim_over;
   logic [W+7:0] lim_under;
   // Compare magnitude*100 against limit*fs so no division is needed
   always_comb begin
      mag = sample[W-1] ? (W+1)'(-$signed({sample[W-1], sample})) : (W+1)'(sample);
      scaled = (W+8)'(mag) * (W+8)'(PCT_FULL);
      lim_over = (W+8)'(FULL_SCALE) * (W+8)'(OVER_PCT);
      lim_under = (W+8)'(FULL_SCALE) * (W+8)'(UNDER_PCT);
      over = scaled > lim_over;
      under = scaled < lim_under;
   end
endmodule

// [design/crt_range_step.sv]
// Range stepping: next distinct range up or down, skipping redundant codes
`timescale 1ns/1ns
module crt_range_step
   import crt_pkg::*;
(
   input wire logic [3:0] cur,
   input wire logic hc_opt,
   output logic [3:0] up,
   output logic [3:0] down
);
   logic [3:0] top;
   // Codes 3, 7, 11 (x1 gain) duplicate the next code, so they are stepped over
   always_comb begin
      top = hc_opt ? RANGE_LAST_HC : RANGE_LAST;
      up = cur;
      down = cur;
      if (cur < top) begin
         up = cur + 4'h1;
         if (up[1:0] == GAIN_X1 && up < top) begin
            up = up + 4'h1;
         end
      end
      if (cur > RANGE_FIRST) begin
         down = cur - 4'h1;
         if (down[1:0] == GAIN_X1) begin
            down = down - 4'h1;
         end
      end
      if (up > top) begin
         up = top;
      end
   end
endmodule

// [design/crt_top.sv]
// Current range and trigger controller: ranging, masking, averaging, sequencing
// Operation
// - Range code picks resistor and gain
// - Codes 3, 7, 11 duplicate next full scale
// - High current option drops range sixteen
// - Hold last good reading one millisecond
// - Host sets fixed range or autoranging
// - Samples flag over 80 under 20 percent
// - Flags captured with average, drive decisions; here captured only while autoranging, always clear in fixed range
// - Over acted at 2 kHz, under 2 Hz
// - Nothing recorded before first trigger
// - External modes: initiate only arms
// - One averaged reading per trigger point
// - Count reached stops recording, ADC runs
// - Trigger points counted from start event
// - Infinite count runs until abort or reset
// - Internal mode starts on initiate
// - Gate active edge starts sequence
// - Start-stop ends after current average
// - Message byte starts the sequence
// - Gate active level is configurable
// - Controller delays start per loop position
// - Orange armed, green running, off done
// - ADC converts at 250 kHz, averaged
// - Averaging period at least 25 conversions
// - Each reading carries incrementing count
`timescale 1ns/1ns
module crt_top
   import crt_pkg::*;
#(
   parameter int AVG_W = 20,
   parameter int CNT_W = 32,
   parameter int UNDER_GAP_P = UNDER_GAP
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic signed [SAMPLE_W-1:0] ADC_DATA,
   input wire logic AUTO_RANGE,
   input wire logic [3:0] FIXED_RANGE,
   input wire logic HIGH_CURRENT_OPTION,
   input wire logic [1:0] TRIG_MODE,
   input wire logic GATE_ACTIVE_HIGH,
   input wire logic GATE_IN,
   input wire logic [AVG_W-1:0] AVG_CONV,
   input wire logic [CNT_W-1:0] TRIG_COUNT,
   input wire logic TRIG_INFINITE,
   input wire logic INITIATE,
   input wire logic ABORT,
   input wire logic START_MSG,
   output logic ADC_CONVERT,
   output logic [1:0] FEEDBACK_SEL,
   output logic [1:0] PROGRAMMABLE_GAIN_STAGE,
   output logic [3:0] RANGE,
   output logic READING_VALID,
   output logic signed [SAMPLE_W+AVG_W-1:0] READING_SUM,
   output logic [CNT_W-1:0] READING_INDEX,
   output logic READING_OVER,
   output logic READING_UNDER,
   output logic [1:0] STATUS_LED,
   output logic BUSY
);
   localparam int SUM_W = SAMPLE_W + AVG_W;
   localparam int DIV_W = $clog2(CONV_DIV);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic gate_d;
      logic [AVG_W-1:0] conv_cnt;
      logic signed [SUM_W-1:0] acc;
      logic acc_over;
      logic acc_under;
      logic [3:0] range;
      logic [7:0] mask_cnt;
      logic [31:0] over_gap;
      logic [31:0] under_gap;
      crt_seq_e seq;
      logic stop_req;
      logic [CNT_W-1:0] done_cnt;
      logic adc_conv;
      logic rd_valid;
      logic signed [SUM_W-1:0] rd_sum;
      logic signed [SUM_W-1:0] good_sum;
      logic [CNT_W-1:0] rd_idx;
      logic rd_over;
      logic rd_under;
      logic [1:0] led;
      logic busy;
   } crt_state_s;

   crt_state_s st_r;
   crt_state_s st_nxt;
   logic rst_meta_r;
   logic rst_sync_r;
   logic rst_sync_b;
   logic smp_over;
   logic smp_under;
   logic [3:0] rng_up;
   logic [3:0] rng_down;

   assign rst_sync_b = rst_sync_r;

   crt_range_check #(.W(SAMPLE_W)) u_check (
      .sample(ADC_DATA),
      .over(smp_over),
      .under(smp_under)
   );

   crt_range_step u_step (
      .cur(st_r.range),
      .hc_opt(HIGH_CURRENT_OPTION),
      .up(rng_up),
      .down(rng_down)
   );

   // Clamp requested range to the selectable set
   function automatic logic [3:0] legal_range(input logic [3:0] r, input logic hc);
      legal_range = (hc && r == RANGE_LAST) ? RANGE_LAST_HC : r;
   endfunction

   // Next-state logic for the whole block
   always_comb begin
      logic conv_tick;
      logic avg_done;
      logic gate_act;
      logic gate_prev;
      logic start_ev;
      logic stop_ev;
      logic [AVG_W-1:0] avg_len;
      logic [3:0] want;
      conv_tick = 1'b0;
      avg_done = 1'b0;
      gate_act = 1'b0;
      gate_prev = 1'b0;
      start_ev = 1'b0;
      stop_ev = 1'b0;
      avg_len = '0;
      want = '0;
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      st_nxt.adc_conv = 1'b0;

      // Free-running conversion strobe, never stopped by the sequencer
      if (st_r.div == DIV_W'(CONV_DIV - 1)) begin
         st_nxt.div = '0;
         conv_tick = 1'b1;
         st_nxt.adc_conv = 1'b1;
      end else begin
         st_nxt.div = st_r.div + DIV_W'(1);
      end

      // Short periods are stretched to the minimum conversion count
      avg_len = (AVG_CONV < AVG_W'(MIN_AVG_CONV)) ? AVG_W'(MIN_AVG_CONV) : AVG_CONV;

      // Accumulate samples, and their range flags only while autoranging
      if (conv_tick) begin
         st_nxt.acc = st_r.acc + SUM_W'(ADC_DATA);
         st_nxt.acc_over = st_r.acc_over | (AUTO_RANGE & smp_over);
         st_nxt.acc_under = st_r.acc_under | (AUTO_RANGE & smp_under);
         if (st_r.conv_cnt == avg_len - AVG_W'(1)) begin
            avg_done = 1'b1;
            st_nxt.conv_cnt = '0;
         end else begin
            st_nxt.conv_cnt = st_r.conv_cnt + AVG_W'(1);
         end
      end

      // Gate edges relative to the configured active level
      gate_act = GATE_IN ~^ GATE_ACTIVE_HIGH;
      gate_prev = st_r.gate_d ~^ GATE_ACTIVE_HIGH;
      st_nxt.gate_d = GATE_IN;

      // Range mask countdown runs in conversions
      if (conv_tick && st_r.mask_cnt != '0) begin
         st_nxt.mask_cnt = st_r.mask_cnt - 8'h1;
      end
      if (st_r.over_gap != '0) begin
         st_nxt.over_gap = st_r.over_gap - 32'h1;
      end
      if (st_r.under_gap != '0) begin
         st_nxt.under_gap = st_r.under_gap - 32'h1;
      end

      // Start events per mode; loop timing alignment is done by the controller
      unique case (crt_mode_e'(TRIG_MODE))
         CRT_TRG_INTERNAL: start_ev = 1'b1;
         CRT_TRG_GATE_START: start_ev = gate_act & ~gate_prev;
         CRT_TRG_GATE_START_STOP: start_ev = gate_act & ~gate_prev;
         CRT_TRG_MESSAGE: start_ev = START_MSG;
      endcase
      stop_ev = (crt_mode_e'(TRIG_MODE) == CRT_TRG_GATE_START_STOP) && !gate_act && gate_prev;

      // End of an average: hand on the sum with its flags
      if (avg_done) begin
         if (st_r.mask_cnt == '0) begin
            st_nxt.good_sum = st_nxt.acc;
         end
         // Decide on range from the captured flags
         if (AUTO_RANGE) begin
            if (st_nxt.acc_over && st_r.over_gap == '0 && rng_up != st_r.range) begin
               st_nxt.range = rng_up;
               st_nxt.mask_cnt = 8'(MASK_CONV);
               st_nxt.over_gap = 32'(OVER_GAP);
               st_nxt.under_gap = 32'(UNDER_GAP_P);
            end else if (!st_nxt.acc_over && st_nxt.acc_under && st_r.under_gap == '0
                         && rng_down != st_r.range) begin
               st_nxt.range = rng_down;
               st_nxt.mask_cnt = 8'(MASK_CONV);
               st_nxt.under_gap = 32'(UNDER_GAP_P);
            end
         end
      end

      // Fixed range: any host change also masks readings
      if (!AUTO_RANGE) begin
         want = legal_range(FIXED_RANGE, HIGH_CURRENT_OPTION);
         if (want != st_r.range) begin
            st_nxt.range = want;
            st_nxt.mask_cnt = 8'(MASK_CONV);
         end
      end else if (st_nxt.range != legal_range(st_nxt.range, HIGH_CURRENT_OPTION)) begin
         st_nxt.range = legal_range(st_nxt.range, HIGH_CURRENT_OPTION);
      end

      // Trigger sequencer
      unique case (st_r.seq)
         CRT_IDLE: begin
            if (INITIATE) begin
               st_nxt.seq = CRT_ARMED;
               st_nxt.led = LED_ORANGE;
               st_nxt.busy = 1'b1;
            end
         end
         CRT_ARMED: begin
            if (start_ev) begin
               st_nxt.seq = CRT_RUN;
               st_nxt.led = LED_GREEN;
               st_nxt.done_cnt = '0;
               st_nxt.stop_req = 1'b0;
               st_nxt.conv_cnt = '0;
               st_nxt.acc = '0;
               st_nxt.acc_over = 1'b0;
               st_nxt.acc_under = 1'b0;
            end
         end
         CRT_RUN: begin
            if (stop_ev) begin
               st_nxt.stop_req = 1'b1;
            end
            if (avg_done) begin
               st_nxt.rd_valid = 1'b1;
               st_nxt.rd_sum = (st_r.mask_cnt != '0) ? st_r.good_sum : st_nxt.good_sum;
               st_nxt.rd_idx = st_r.done_cnt;
               st_nxt.rd_over = st_nxt.acc_over;
               st_nxt.rd_under = st_nxt.acc_under;
               st_nxt.done_cnt = st_r.done_cnt + CNT_W'(1);
               if ((!TRIG_INFINITE && st_r.done_cnt + CNT_W'(1) >= TRIG_COUNT)
                   || st_r.stop_req || stop_ev) begin
                  st_nxt.seq = CRT_IDLE;
                  st_nxt.led = LED_OFF;
                  st_nxt.busy = 1'b0;
               end
            end
         end
         default: st_nxt.seq = CRT_IDLE;
      endcase

      // Clear the accumulator only once reading and range logic have taken its totals
      if (avg_done) begin
         st_nxt.acc = '0;
         st_nxt.acc_over = 1'b0;
         st_nxt.acc_under = 1'b0;
      end

      // Abort wins over everything in the sequencer
      if (ABORT) begin
         st_nxt.seq = CRT_IDLE;
         st_nxt.led = LED_OFF;
         st_nxt.busy = 1'b0;
         st_nxt.rd_valid = 1'b0;
      end
   end

   // Reset synchroniser sits outside the state record since it runs on the raw reset
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Main state register
   always_ff @(posedge CORE_CLK or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_r.div <= '0;
         st_r.gate_d <= 1'b0;
         st_r.conv_cnt <= '0;
         st_r.acc <= '0;
         st_r.acc_over <= 1'b0;
         st_r.acc_under <= 1'b0;
         st_r.range <= RANGE_FIRST;
         st_r.mask_cnt <= '0;
         st_r.over_gap <= '0;
         st_r.under_gap <= '0;
         st_r.seq <= CRT_IDLE;
         st_r.stop_req <= 1'b0;
         st_r.done_cnt <= '0;
         st_r.adc_conv <= 1'b0;
         st_r.rd_valid <= 1'b0;
         st_r.rd_sum <= '0;
         st_r.good_sum <= '0;
         st_r.rd_idx <= '0;
         st_r.rd_over <= 1'b0;
         st_r.rd_under <= 1'b0;
         st_r.led <= LED_OFF;
         st_r.busy <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign ADC_CONVERT = st_r.adc_conv;
   assign FEEDBACK_SEL = st_r.range[3:2];
   assign PROGRAMMABLE_GAIN_STAGE = st_r.range[1:0];
   assign RANGE = st_r.range;
   assign READING_VALID = st_r.rd_valid;
   assign READING_SUM = st_r.rd_sum;
   assign READING_INDEX = st_r.rd_idx;
   assign READING_OVER = st_r.rd_over;
   assign READING_UNDER = st_r.rd_under;
   assign STATUS_LED = st_r.led;
   assign BUSY = st_r.busy;
endmodule

// [verification/crt_top_props.sv]
// Checker: port-level sequencing and timing properties of the controller
`timescale 1ns/1ns
module crt_top_props
   import crt_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [1:0] TRIG_MODE,
   input wire logic HIGH_CURRENT_OPTION,
   input wire logic INITIATE,
   input wire logic ABORT,
   input wire logic START_MSG,
   input wire logic ADC_CONVERT,
   input wire logic [1:0] FEEDBACK_SEL,
   input wire logic [1:0] PROGRAMMABLE_GAIN_STAGE,
   input wire logic [3:0] RANGE,
   input wire logic READING_VALID,
   input wire logic [CNT_W-1:0] READING_INDEX,
   input wire logic [1:0] STATUS_LED,
   input wire logic BUSY
);
   logic [15:0] conv_gap;
   logic conv_seen;
   logic [CNT_W-1:0] last_idx;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // Gap since the last strobe; the first strobe after reset has no reference
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         conv_gap <= 16'h0000;
         conv_seen <= 1'b0;
         last_idx <= '0;
      end else begin
         conv_gap <= ADC_CONVERT ? 16'h0000 : conv_gap + 16'h0001;
         conv_seen <= conv_seen | ADC_CONVERT;
         if (READING_VALID) begin
            last_idx <= READING_INDEX;
         end
      end
   end
   // Sequencer, ranging and conversion timing
   chk_init_arms: assert property (!BUSY && INITIATE && !ABORT |=> STATUS_LED == LED_ORANGE && BUSY)
      else $error("initiate did not arm");
   chk_abort_idle: assert property (ABORT |=> STATUS_LED == LED_OFF && !BUSY)
      else $error("abort did not return to idle");
   chk_msg_waits: assert property (STATUS_LED == LED_ORANGE && TRIG_MODE == 2'h3 && !START_MSG
      && !ABORT |=> STATUS_LED == LED_ORANGE)
      else $error("left armed state without start message");
   chk_range_map: assert property (FEEDBACK_SEL == RANGE[3:2]
      && PROGRAMMABLE_GAIN_STAGE == RANGE[1:0])
      else $error("resistor or gain does not follow range");
   chk_hc_top: assert property (HIGH_CURRENT_OPTION [*3] |-> RANGE != RANGE_LAST)
      else $error("top range selected with high current option");
   chk_conv_gap: assert property (ADC_CONVERT && conv_seen |-> conv_gap == 16'(CONV_DIV - 1))
      else $error("conversion strobe spacing wrong");
   chk_valid_run: assert property (READING_VALID |-> $past(STATUS_LED) == LED_GREEN)
      else $error("reading outside a running sequence");
   chk_index_step: assert property (READING_VALID && READING_INDEX != 0
      |-> READING_INDEX == last_idx + 1'b1)
      else $error("reading index did not step by one");
endmodule
bind crt_top crt_top_props #(.CNT_W(CNT_W)) crt_top_props_inst (.CORE_CLK(CORE_CLK),
   .RST_B(RST_B), .TRIG_MODE(TRIG_MODE), .HIGH_CURRENT_OPTION(HIGH_CURRENT_OPTION),
   .INITIATE(INITIATE), .ABORT(ABORT), .START_MSG(START_MSG), .ADC_CONVERT(ADC_CONVERT),
   .FEEDBACK_SEL(FEEDBACK_SEL), .PROGRAMMABLE_GAIN_STAGE(PROGRAMMABLE_GAIN_STAGE),
   .RANGE(RANGE), .READING_VALID(READING_VALID), .READING_INDEX(READING_INDEX),
   .STATUS_LED(STATUS_LED), .BUSY(BUSY));

// [verification/crt_host_model.sv]
// Far-side model: analog source level seen by the converter and the optical gate line
`timescale 1ns/1ns
module crt_host_model
   import crt_pkg::*;
(
   input wire logic clk,
   input wire logic signed [SAMPLE_W-1:0] level,
   input wire logic gate_on,
   input wire logic act_high,
   output logic signed [SAMPLE_W-1:0] adc_data,
   output logic gate_line
);
   // Gate light follows the chosen sense, so active may mean a dark fibre
   always @(posedge clk) begin
      adc_data <= level;
      gate_line <= gate_on ~^ act_high;
   end
endmodule

// [verification/crt_top_tb.sv]
// Testbench: trigger modes, averaging, autoranging, abort and range map
`timescale 1ns/1ns
module crt_top_tb
   import crt_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic auto_range = 1'b0, hc_opt = 1'b0, gate_hi = 1'b1, gate_on = 1'b0, trig_inf = 1'b0;
   logic initiate = 1'b0, abort_p = 1'b0, start_msg = 1'b0;
   logic [3:0] fixed_range = 4'h0; // Same as the reset range, so no masking at start
   logic [1:0] trig_mode = 2'h0;
   logic signed [15:0] level = 16'sh2000;
   logic [19:0] avg_conv = 20'h00019;
   logic [31:0] trig_count = 32'h00000001;
   logic signed [15:0] adc;
   logic gate_in, adc_convert, rd_valid, rd_over, rd_under, busy;
   logic [1:0] fb_sel, gain_sel, status_led;
   logic [3:0] range_code;
   logic signed [35:0] rd_sum;
   logic [31:0] rd_index;
   integer seed = 9;
   int num_errors = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   crt_host_model crt_host_model_inst (.clk(clk), .level(level), .gate_on(gate_on),
      .act_high(gate_hi), .adc_data(adc), .gate_line(gate_in));
   crt_top #(.UNDER_GAP_P(2000)) crt_top_inst (.CORE_CLK(clk), .RST_B(rst_b), .ADC_DATA(adc),
      .AUTO_RANGE(auto_range), .FIXED_RANGE(fixed_range), .HIGH_CURRENT_OPTION(hc_opt),
      .TRIG_MODE(trig_mode), .GATE_ACTIVE_HIGH(gate_hi), .GATE_IN(gate_in),
      .AVG_CONV(avg_conv), .TRIG_COUNT(trig_count), .TRIG_INFINITE(trig_inf),
      .INITIATE(initiate), .ABORT(abort_p), .START_MSG(start_msg), .ADC_CONVERT(adc_convert),
      .FEEDBACK_SEL(fb_sel), .PROGRAMMABLE_GAIN_STAGE(gain_sel), .RANGE(range_code),
      .READING_VALID(rd_valid), .READING_SUM(rd_sum), .READING_INDEX(rd_index),
      .READING_OVER(rd_over), .READING_UNDER(rd_under), .STATUS_LED(status_led), .BUSY(busy));
   // Autorange step up skips codes that repeat the next full scale
   function automatic logic [3:0] next_up(input logic [3:0] r);
      logic [3:0] u;
      u = r + 4'h1;
      if (u == 4'h3 || u == 4'h7 || u == 4'hB) u = u + 4'h1;
      return u;
   endfunction
   // Short averaging requests are raised to the minimum period
   function automatic int eff_avg(input logic [4:0] n);
      return (n < 5'h19) ? 25 : int'(n);
   endfunction
   task chk_code(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t code got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_num(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t value got %h exp %h", $time, got, exp);
      end
   endtask
   // One-cycle command strobe: 0 initiate, 1 start message, 2 abort
   task pulse(input int w);
      @(posedge clk);
      initiate <= (w == 0);
      start_msg <= (w == 1);
      abort_p <= (w == 2);
      @(posedge clk);
      initiate <= 1'b0;
      start_msg <= 1'b0;
      abort_p <= 1'b0;
   endtask
   // Bounded wait: one reading takes at most 31 conversions of 400 clocks
   task automatic wait_valid();
      int k;
      for (k = 0; k < 14000; k++) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) break;
      end
      if (k == 14000) begin
         num_errors++;
         $display("[ERR] %0t no reading", $time);
      end
   endtask
   task automatic run_seq(input logic [1:0] mode, input logic act, input int tc, input int nexp,
      input logic stop);
      logic [31:0] rv;
      logic signed [15:0] lvl;
      int n;
      rv = $random(seed);
      lvl = 16'sh2000 | rv[11:0];
      n = eff_avg(rv[16:12]);
      @(posedge clk);
      level <= lvl;
      avg_conv <= {15'h0000, rv[16:12]};
      trig_mode <= mode;
      trig_count <= tc;
      gate_hi <= act;
      repeat (3) @(posedge clk);
      pulse(0);
      #1;
      chk_code(status_led, LED_ORANGE);
      if (mode != CRT_TRG_INTERNAL) begin
         repeat (5) @(posedge clk);
         #1;
         chk_code(status_led, LED_ORANGE);
         if (mode == CRT_TRG_MESSAGE) pulse(1);
         else begin
            @(posedge clk);
            gate_on <= 1'b1;
         end
      end
      // Gate drops in mid-average; the average in progress must still come out
      if (stop) begin
         repeat (200) @(posedge clk);
         gate_on <= 1'b0;
      end
      for (int i = 0; i < nexp; i++) begin
         wait_valid();
         chk_num({{28{rd_sum[35]}}, rd_sum}, 64'(longint'(lvl) * n));
         chk_num(64'(rd_index), 64'(i));
      end
      @(posedge clk);
      gate_on <= 1'b0;
      #1;
      chk_code(status_led, LED_OFF);
      chk_code(busy, 1'b0);
   endtask
   task conclude();
      $display("Errors %0d, compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      logic [3:0] rexp;
      int got;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      run_seq(CRT_TRG_INTERNAL, 1'b1, 2, 2, 1'b0);
      run_seq(CRT_TRG_GATE_START, 1'b0, 1, 1, 1'b0);
      run_seq(CRT_TRG_GATE_START_STOP, 1'b1, 4, 1, 1'b1);
      run_seq(CRT_TRG_MESSAGE, 1'b1, 1, 1, 1'b0);
      // Autorange on a hot signal with unlimited count, then abort
      @(posedge clk);
      level <= 16'sh7000;
      trig_mode <= CRT_TRG_INTERNAL;
      avg_conv <= 20'h00019;
      trig_count <= 32'h00000000;
      trig_inf <= 1'b1;
      auto_range <= 1'b1;
      pulse(0);
      wait_valid();
      chk_num({{28{rd_sum[35]}}, rd_sum}, 64'h00000000000AF000);
      chk_code(rd_over, 1'b1);
      chk_code(rd_under, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk_code(range_code, next_up(4'h0));
      pulse(2);
      #1;
      chk_code(status_led, LED_OFF);
      got = 0;
      repeat (11000) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) got++;
      end
      chk_num(64'(got), 64'h0);
      // Fixed range walk with and without the high current option
      for (int k = 0; k < 32; k++) begin
         @(posedge clk);
         auto_range <= 1'b0;
         fixed_range <= k[3:0];
         hc_opt <= k[4];
         repeat (3) @(posedge clk);
         #1;
         rexp = (k[4] && k[3:0] == 4'hF) ? 4'hE : k[3:0];
         chk_code(range_code, rexp);
         chk_code({2'b00, fb_sel}, {2'b00, rexp[3:2]});
         chk_code({2'b00, gain_sel}, {2'b00, rexp[1:0]});
      end
      conclude();
   end
endmodule
